// ===== rtl/odm_cfg.svh
// constants for the output dependency matrix: offsets, fields, reset values
`ifndef ODM_CFG_SVH
`define ODM_CFG_SVH

// ============================================================
// register indexes (byte address is four times the index)
`define ODM_IDX_O6T1_PRI 7'h2B
`define ODM_IDX_O6T1_SEC 7'h2C
`define ODM_IDX_O6T1_IO 7'h2D
`define ODM_IDX_O6T2_PRI 7'h2E
`define ODM_IDX_O6T2_SEC 7'h2F
`define ODM_IDX_O6T2_IO 7'h30
`define ODM_IDX_O6_CFG 7'h31
`define ODM_IDX_O7_PRI 7'h32
`define ODM_IDX_O7_SEC 7'h33
`define ODM_IDX_O7_IO 7'h34
`define ODM_IDX_O7_CFG 7'h35
`define ODM_IDX_O8_DEP 7'h3B
`define ODM_IDX_MR_MASK 7'h40
`define ODM_IDX_STATUS 7'h50

// ============================================================
// field positions
`define ODM_O6T1_O8_BIT 0
`define ODM_O6T2_O8_BIT 5
`define ODM_O7_O8_BIT 0
`define ODM_MR_O6_BIT 5
`define ODM_MR_O7_BIT 6

// ============================================================
// reset values
`define ODM_MASK_RST 8'h00
`define ODM_ACK_RST 1'b0

`endif

// ===== rtl/odm_pkg.sv
// types for the output dependency matrix
package odm_pkg;

  // ============================================================
  // classic wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [8:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // ============================================================
  // monitored conditions, each bit high means no fault
  typedef struct packed {
    logic [5:0] primary_ok;
    logic [5:0] secondary_ok;
    logic [1:0] watchdog_ok;
    logic [3:0] logic_in;
  } cond_t;

  // three mask bytes of one product term
  typedef struct packed {
    logic [7:0] io;
    logic [7:0] sec;
    logic [7:0] pri;
  } term_mask_t;

endpackage

// ===== rtl/output_dependency_matrix.sv
// dependency logic for programmable outputs six and seven, wishbone registers
`timescale 1ns/1ps
`include "odm_cfg.svh"

module output_dependency_matrix
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // register bus
  input odm_pkg::wb_req_t WB_REQ,
  output odm_pkg::wb_rsp_t WB_RSP,
  // monitored conditions
  input odm_pkg::cond_t COND,
  input wire logic MANUAL_RESET_N,
  // other outputs asserted: bits one to five, then eight
  input wire logic [5:0] OTHER_ASSERTED,
  // dependent outputs, logical assert level
  output logic PROG_OUTPUT_SIX,
  output logic PROG_OUTPUT_SEVEN
);
  import odm_pkg::*;

  // ============================================================
  // registers
  term_mask_t o6t1;
  term_mask_t o6t2;
  term_mask_t o7m;
  logic [7:0] o6_cfg;
  logic [7:0] o7_cfg;
  logic [7:0] o8_dep;
  logic [7:0] mr_mask;
  logic ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [6:0] idx;
  logic wr_en;
  logic wr_byte;

  // other outputs
  logic o1_asserted;
  logic o2_asserted;
  logic o3_asserted;
  logic o4_asserted;
  logic o5_asserted;
  logic o8_asserted;

  // term evaluation
  logic [23:0] ok6;
  logic [23:0] ok7;
  logic term6a;
  logic term6b;
  logic term7;
  logic next_six;
  logic next_seven;

  assign idx = WB_REQ.adr[8:2];
  assign wr_en = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & ~ack;
  // only the low byte lane holds register bits
  assign wr_byte = wr_en & WB_REQ.sel[0];

  // ============================================================
  // mask register writes
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      o6t1 <= {3{`ODM_MASK_RST}};
      o6t2 <= {3{`ODM_MASK_RST}};
      o7m <= {3{`ODM_MASK_RST}};
      o6_cfg <= `ODM_MASK_RST;
      o7_cfg <= `ODM_MASK_RST;
      o8_dep <= `ODM_MASK_RST;
      mr_mask <= `ODM_MASK_RST;
    end
    else if (wr_byte)
    begin
      unique case (idx)
        `ODM_IDX_O6T1_PRI: o6t1.pri <= WB_REQ.dat[7:0];
        `ODM_IDX_O6T1_SEC: o6t1.sec <= WB_REQ.dat[7:0];
        `ODM_IDX_O6T1_IO: o6t1.io <= WB_REQ.dat[7:0];
        `ODM_IDX_O6T2_PRI: o6t2.pri <= WB_REQ.dat[7:0];
        `ODM_IDX_O6T2_SEC: o6t2.sec <= WB_REQ.dat[7:0];
        `ODM_IDX_O6T2_IO: o6t2.io <= WB_REQ.dat[7:0];
        `ODM_IDX_O6_CFG: o6_cfg <= WB_REQ.dat[7:0];
        `ODM_IDX_O7_PRI: o7m.pri <= WB_REQ.dat[7:0];
        `ODM_IDX_O7_SEC: o7m.sec <= WB_REQ.dat[7:0];
        `ODM_IDX_O7_IO: o7m.io <= WB_REQ.dat[7:0];
        `ODM_IDX_O7_CFG: o7_cfg <= WB_REQ.dat[7:0];
        `ODM_IDX_O8_DEP: o8_dep <= WB_REQ.dat[7:0];
        `ODM_IDX_MR_MASK: mr_mask <= WB_REQ.dat[7:0];
        default:
        begin
          // unmapped writes are acknowledged and dropped
        end
      endcase
    end
  end

  // ============================================================
  // read mux; unmapped and reserved read as zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (idx)
      `ODM_IDX_O6T1_PRI: next_rdata[7:0] = o6t1.pri;
      `ODM_IDX_O6T1_SEC: next_rdata[7:0] = o6t1.sec;
      `ODM_IDX_O6T1_IO: next_rdata[7:0] = o6t1.io;
      `ODM_IDX_O6T2_PRI: next_rdata[7:0] = o6t2.pri;
      `ODM_IDX_O6T2_SEC: next_rdata[7:0] = o6t2.sec;
      `ODM_IDX_O6T2_IO: next_rdata[7:0] = o6t2.io;
      `ODM_IDX_O6_CFG: next_rdata[7:0] = o6_cfg;
      `ODM_IDX_O7_PRI: next_rdata[7:0] = o7m.pri;
      `ODM_IDX_O7_SEC: next_rdata[7:0] = o7m.sec;
      `ODM_IDX_O7_IO: next_rdata[7:0] = o7m.io;
      `ODM_IDX_O7_CFG: next_rdata[7:0] = o7_cfg;
      `ODM_IDX_O8_DEP: next_rdata[7:0] = o8_dep;
      `ODM_IDX_MR_MASK: next_rdata[7:0] = mr_mask;
      `ODM_IDX_STATUS: next_rdata[4:0] = {term7, term6b, term6a, PROG_OUTPUT_SEVEN,
                                          PROG_OUTPUT_SIX};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // ============================================================
  // bus answer: one wait state, ack drops the cycle after it rose
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ack <= `ODM_ACK_RST;
    end
    else
    begin
      ack <= WB_REQ.cyc & WB_REQ.stb & ~ack;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      rdata <= 32'h00000000;
    end
    else if (WB_REQ.cyc & WB_REQ.stb & ~ack & ~WB_REQ.we)
    begin
      rdata <= next_rdata;
    end
  end

  assign WB_RSP.ack = ack;
  assign WB_RSP.dat = rdata;

  // ============================================================
  // no-fault vectors; an output is healthy while it is not asserted
  assign o1_asserted = OTHER_ASSERTED[0];
  assign o2_asserted = OTHER_ASSERTED[1];
  assign o3_asserted = OTHER_ASSERTED[2];
  assign o4_asserted = OTHER_ASSERTED[3];
  assign o5_asserted = OTHER_ASSERTED[4];
  assign o8_asserted = OTHER_ASSERTED[5];

  // six and seven feed each other from flops, so no combinational loop
  assign ok6 = {~PROG_OUTPUT_SEVEN, ~o5_asserted, ~o4_asserted, ~o3_asserted,
                ~o2_asserted, ~o1_asserted, COND.logic_in[3:2],
                COND.logic_in[1:0], COND.secondary_ok,
                COND.watchdog_ok, COND.primary_ok};
  assign ok7 = {~PROG_OUTPUT_SIX, ~o5_asserted, ~o4_asserted, ~o3_asserted,
                ~o2_asserted, ~o1_asserted, COND.logic_in[3:2],
                COND.logic_in[1:0], COND.secondary_ok,
                COND.watchdog_ok, COND.primary_ok};

  // ============================================================
  // product terms: masked-off bits contribute a one
  assign term6a = (&(~o6t1 | ok6))
                & (~o6_cfg[`ODM_O6T1_O8_BIT] | ~o8_asserted);
  assign term6b = (&(~o6t2 | ok6))
                & (~o8_dep[`ODM_O6T2_O8_BIT] | ~o8_asserted);
  assign term7 = (&(~o7m | ok7))
               & (~o7_cfg[`ODM_O7_O8_BIT] | ~o8_asserted);

  // ============================================================
  // output state; small-variant bits left at zero simply drop out
  assign next_six = (mr_mask[`ODM_MR_O6_BIT] & ~MANUAL_RESET_N)
                  | ~(term6a | term6b);
  assign next_seven = (mr_mask[`ODM_MR_O7_BIT] & ~MANUAL_RESET_N)
                    | ~term7;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      // held asserted in reset so supplies stay off
      PROG_OUTPUT_SIX <= 1'b1;
      PROG_OUTPUT_SEVEN <= 1'b1;
    end
    else
    begin
      PROG_OUTPUT_SIX <= next_six;
      PROG_OUTPUT_SEVEN <= next_seven;
    end
  end

endmodule

// ===== tb/odm_properties.sv
// port checker for the output dependency matrix
`timescale 1ns/1ps
module odm_properties
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // watched ports
  input odm_pkg::wb_req_t WB_REQ,
  input odm_pkg::wb_rsp_t WB_RSP,
  input odm_pkg::cond_t COND,
  input wire logic MANUAL_RESET_N,
  input wire logic [5:0] OTHER_ASSERTED,
  input wire logic PROG_OUTPUT_SIX,
  input wire logic PROG_OUTPUT_SEVEN
);
  import odm_pkg::*;
  logic [7:0] mr;
  wire logic req = WB_REQ.cyc && WB_REQ.stb;
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // ========
  // manual reset mask shadow, stored at the taking edge
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      mr <= 8'h00;
    else if (req && !WB_RSP.ack && WB_REQ.we && WB_REQ.sel[0] && WB_REQ.adr[8:2] == 7'h40)
      mr <= WB_REQ.dat[7:0];
  end
  sequence s_take; req && !WB_RSP.ack; endsequence
  sequence s_calm; $stable({COND, MANUAL_RESET_N, OTHER_ASSERTED}) && !req; endsequence
  property p_ack; s_take |=> WB_RSP.ack; endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_pulse; WB_RSP.ack |=> !WB_RSP.ack; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_idle; !req |=> !WB_RSP.ack; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_dat; WB_RSP.ack |-> WB_RSP.dat[31:8] == 24'h000000; endproperty
  a_dat: assert property (p_dat) else $error("high read bits");
  property p_mrrd;
    WB_RSP.ack && !WB_REQ.we && WB_REQ.adr[8:2] == 7'h40 |-> WB_RSP.dat[7:0] == mr; endproperty
  a_mrrd: assert property (p_mrrd) else $error("mask readback");
  property p_rst;
    disable iff (1'b0) RESET |=> PROG_OUTPUT_SIX && PROG_OUTPUT_SEVEN; endproperty
  a_rst: assert property (p_rst) else $error("reset level");
  property p_mr6; mr[5] && !MANUAL_RESET_N |=> PROG_OUTPUT_SIX; endproperty
  a_mr6: assert property (p_mr6) else $error("six not forced");
  property p_mr7; mr[6] && !MANUAL_RESET_N |=> PROG_OUTPUT_SEVEN; endproperty
  a_mr7: assert property (p_mr7) else $error("seven not forced");
  // four calm edges let the six-seven chain settle
  property p_calm; s_calm [*4] |=> $stable({PROG_OUTPUT_SIX, PROG_OUTPUT_SEVEN}); endproperty
  a_calm: assert property (p_calm) else $error("output moved");
endmodule

// ===== tb/supply_rails.sv
// supply rail model fed by the dependent outputs
`timescale 1ns/1ps
module supply_rails
(
  // outputs in, rails out; a rail turns on once its output releases
  input wire logic clk,
  input wire logic six,
  input wire logic seven,
  output logic [1:0] rail_on
);
  always_ff @(posedge clk)
    rail_on <= {~seven, ~six};
endmodule

// ===== tb/output_dependency_matrix_tb.sv
// bench for the output dependency matrix
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t %h %h", $time, (a), (b)); end end
module output_dependency_matrix_tb;
  import odm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, mr_n = 1'b1, o8 = 1'b0, six, seven;
  logic [23:0] f = 24'h000000;
  logic [7:0] rd;
  logic [6:0] a;
  logic [1:0] rails;
  // byte enables of the next request; only lane zero carries register bits
  logic [3:0] be = 4'hF;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  int err_total = 0, check_count = 0, cycles = 0;
  logic [6:0] rg [14] = '{7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h30, 7'h31, 7'h32, 7'h33,
    7'h34, 7'h35, 7'h3B, 7'h40, 7'h7F};
  // a set bit of f is a fault on that condition
  output_dependency_matrix i_dut
  (
    .REF_CLK(clk), .RESET(rst), .WB_REQ(req), .WB_RSP(rsp), .MANUAL_RESET_N(mr_n),
    .COND({~f[5:0], ~f[13:8], ~f[7:6], ~f[17:16], ~f[15:14]}),
    .OTHER_ASSERTED({o8, f[22:18]}), .PROG_OUTPUT_SIX(six), .PROG_OUTPUT_SEVEN(seven)
  );
  supply_rails i_rails (.clk(clk), .six(six), .seven(seven), .rail_on(rails));
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 8000)
      give_verdict(1'b1);
  end
  task automatic give_verdict(input logic late);
    err_total += late;
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic [6:0] ad, input logic w, input logic [7:0] d);
    req <= '{1'b1, 1'b1, w, {ad, 2'b00}, be, {24'h000000, d}};
    @(posedge clk);
    while (rsp.ack !== 1'b1)
      @(posedge clk);
    rd = rsp.dat[7:0];
    req <= '0;
    @(posedge clk);
  endtask
  task automatic chk_out(input logic e6, input logic e7);
    repeat (4) @(posedge clk);
    `CHK(six, e6)
    `CHK(seven, e7)
    `CHK(rails, {~e7, ~e6})
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_out(1'b0, 1'b0);
    // ========
    // one mask bit at a time; output eight pins the other six term low
    for (int t = 0; t < 3; t++)
    begin
      o8 <= (t < 2);
      wb(7'h31, 1'b1, {7'h00, t == 1});
      wb(7'h3B, 1'b1, (t == 0) ? 8'h20 : 8'h00);
      for (int i = 0; i < 23; i++)
      begin
        a = rg[3 * t + t / 2 + i / 8];
        wb(a, 1'b1, 8'h01 << (i % 8));
        chk_out(1'b0, 1'b0);
        f <= 24'h000001 << i;
        chk_out(t < 2, t == 2);
        f <= 24'h000000;
        wb(a, 1'b1, 8'h00);
      end
    end
    o8 <= 1'b1;
    wb(7'h35, 1'b1, 8'h01);
    chk_out(1'b0, 1'b1);
    o8 <= 1'b0;
    mr_n <= 1'b0;
    chk_out(1'b0, 1'b0);
    wb(7'h40, 1'b1, 8'h20);
    chk_out(1'b1, 1'b0);
    wb(7'h34, 1'b1, 8'h80);
    chk_out(1'b1, 1'b1);
    // status: seven term false, both six terms true, six forced by manual reset
    wb(7'h50, 1'b0, 8'h00);
    `CHK(rd, 8'h0F)
    wb(7'h40, 1'b1, 8'h40);
    chk_out(1'b0, 1'b1);
    mr_n <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({six, seven}, 2'b11)
    rst <= 1'b0;
    foreach (rg[k])
    begin
      wb(rg[k], 1'b0, 8'h00);
      `CHK(rd, 8'h00)
      wb(rg[k], 1'b1, 8'hA5 ^ 8'(k));
      wb(rg[k], 1'b0, 8'h00);
      `CHK(rd, (k == 13) ? 8'h00 : 8'hA5 ^ 8'(k))
    end
    // a write without lane zero must leave the mask alone
    be = 4'hE;
    wb(7'h2B, 1'b1, 8'h5A);
    be = 4'hF;
    wb(7'h2B, 1'b0, 8'h00);
    `CHK(rd, 8'hA5)
    give_verdict(1'b0);
  end
endmodule
bind output_dependency_matrix odm_properties i_props
(
  .REF_CLK(REF_CLK), .RESET(RESET), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .COND(COND),
  .MANUAL_RESET_N(MANUAL_RESET_N), .OTHER_ASSERTED(OTHER_ASSERTED),
  .PROG_OUTPUT_SIX(PROG_OUTPUT_SIX), .PROG_OUTPUT_SEVEN(PROG_OUTPUT_SEVEN)
);
